//--- verilog/ssq_sequencer.sv
// Stepper phase sequencer with AHB-Lite register slave and interrupt.
// Assumes the eight motor input pins are asynchronous to CORE_CLK; SRST and AHB run on CORE_CLK.
`timescale 1ns/1ps
`include "ssq_defs.svh"

module ssq_sequencer (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic STEP_CLK,
  input wire logic EXCITATION_SELECT,
  input wire logic EDGE_SELECT,
  input wire logic DIRECTION_SELECT,
  input wire logic RESET_N_IN,
  input wire logic ENABLE,
  input wire logic OVERCURRENT,
  input wire logic OVERHEAT,
  output logic FIRST_WINDING_FWD,
  output logic FIRST_WINDING_REV,
  output logic SECOND_WINDING_FWD,
  output logic SECOND_WINDING_REV,
  output logic ALARM_O,
  output logic ALARM_OE_N,
  output logic IRQ,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP
);

  // ==========================================================
  // Pin synchronisers
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic step_d;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sync1 <= `SSQ_SYNC_RESET;
      sync2 <= `SSQ_SYNC_RESET;
    end else begin
      sync1 <= {OVERHEAT, RESET_N_IN, ENABLE, DIRECTION_SELECT,
                EDGE_SELECT, EXCITATION_SELECT, OVERCURRENT, STEP_CLK};
      sync2 <= sync1;
    end
  end

  logic step_s;
  logic oc_s;
  logic exc_s;
  logic edge_s;
  logic dir_s;
  logic en_s;
  logic rstn_s;
  logic oh_s;
  assign step_s = sync2[0];
  assign oc_s = sync2[1];
  assign exc_s = sync2[2];
  assign edge_s = sync2[3];
  assign dir_s = sync2[4];
  assign en_s = sync2[5];
  assign rstn_s = sync2[6];
  assign oh_s = sync2[7];

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      step_d <= 1'b0;
    end else begin
      step_d <= step_s;
    end
  end

  // ==========================================================
  // Sequencer core
  logic int_rst;
  logic rise;
  logic fall;
  logic step_evt;
  logic run;
  logic fault;
  ssq_pkg::ssq_pos_t pos;
  ssq_pkg::ssq_pos_t next_pos;

  assign int_rst = SRST | ~rstn_s;
  assign rise = step_s & ~step_d;
  assign fall = ~step_s & step_d;
  // Enable low freezes the position (the fault latch still sets), so edges meanwhile are ignored
  assign step_evt = en_s & ~fault & (rise | (fall & ~edge_s));

  // Step size: half mode moves 1; full mode moves 2, or 1 from a half state
  function automatic ssq_pkg::ssq_pos_t step_amount(input logic half,
                                                      input ssq_pkg::ssq_pos_t p);
    if (half || p[0]) begin
      step_amount = `SSQ_POS_ONE;
    end else begin
      step_amount = `SSQ_POS_TWO;
    end
  endfunction : step_amount

  // Even positions energise two windings, odd positions one
  function automatic ssq_pkg::ssq_wind_t pattern(input ssq_pkg::ssq_pos_t p);
    case (p)
      3'h0: pattern = 4'h9;
      3'h1: pattern = 4'h1;
      3'h2: pattern = 4'h5;
      3'h3: pattern = 4'h4;
      3'h4: pattern = 4'h6;
      3'h5: pattern = 4'h2;
      3'h6: pattern = 4'ha;
      3'h7: pattern = 4'h8;
      default: pattern = `SSQ_WIND_OFF;
    endcase
  endfunction : pattern

  always_comb begin
    if (dir_s) begin
      next_pos = pos - step_amount(exc_s, pos);
    end else begin
      next_pos = pos + step_amount(exc_s, pos);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (int_rst) begin
      pos <= `SSQ_POS_HOME;
    end else if (step_evt) begin
      pos <= next_pos;
    end
  end

  // Latch cleared only by power-on or the reset pin
  always_ff @(posedge CORE_CLK) begin
    if (int_rst) begin
      fault <= 1'b0;
    end else if (oc_s | oh_s) begin
      fault <= 1'b1;
    end
  end

  // ==========================================================
  // Registers
  logic ctrl_run;
  logic [`SSQ_IRQ_W-1:0] irq_status;
  logic [`SSQ_IRQ_W-1:0] irq_mask;
  logic [`SSQ_IRQ_W-1:0] irq_set;
  logic wr_pend;
  logic [`SSQ_ADDR_MSB:0] wr_addr;
  logic acc;
  ssq_pkg::ssq_word_t rd_val;
  ssq_pkg::ssq_wind_t wind;

  assign run = ctrl_run;
  assign acc = HSEL & HTRANS[1] & HREADY;
  assign irq_set = {~fault & (oc_s | oh_s) & ~int_rst, step_evt & ~int_rst};

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc & HWRITE;
      wr_addr <= HADDR[`SSQ_ADDR_MSB:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_run <= 1'(`SSQ_CTRL_RESET);
    end else if (wr_pend && wr_addr == `SSQ_CTRL_OFS) begin
      ctrl_run <= HWDATA[`SSQ_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_mask <= 2'h0;
    end else if (wr_pend && wr_addr == `SSQ_IRQ_MASK_OFS) begin
      irq_mask <= HWDATA[`SSQ_IRQ_W-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_status <= 2'h0;
    end else if (wr_pend && wr_addr == `SSQ_IRQ_STATUS_OFS) begin
      irq_status <= (irq_status & ~HWDATA[`SSQ_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_comb begin
    case (HADDR[`SSQ_ADDR_MSB:0])
      `SSQ_CTRL_OFS: rd_val = {31'h0, ctrl_run};
      `SSQ_STATE_OFS: rd_val = {20'h0, fault, en_s, rstn_s, dir_s,
                                edge_s, exc_s, 3'h0, pos};
      `SSQ_IRQ_STATUS_OFS: rd_val = {30'h0, irq_status};
      `SSQ_IRQ_MASK_OFS: rd_val = {30'h0, irq_mask};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (acc && !HWRITE) begin
        HRDATA <= rd_val;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign wind = (en_s & ~fault & ~int_rst & run) ? pattern(pos) : `SSQ_WIND_OFF;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      {SECOND_WINDING_REV, SECOND_WINDING_FWD, FIRST_WINDING_REV,
       FIRST_WINDING_FWD} <= `SSQ_WIND_OFF;
      ALARM_O <= 1'b0;
      ALARM_OE_N <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      {SECOND_WINDING_REV, SECOND_WINDING_FWD, FIRST_WINDING_REV,
       FIRST_WINDING_FWD} <= wind;
      ALARM_O <= 1'b0;
      ALARM_OE_N <= ~fault;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  // Stepping
  a_step_moves: assert property (step_evt && !int_rst |=> pos != $past(pos))
    else $error("active step edge did not move position");
  a_no_edge_hold: assert property (!step_evt && !int_rst |=> pos == $past(pos))
    else $error("position moved without step edge");
  a_rise_only: assert property (fall && edge_s |-> !step_evt)
    else $error("falling edge stepped in rising-only mode");
  a_half_fwd: assert property (step_evt && exc_s && !dir_s && !int_rst
      |=> pos == $past(pos) + 3'h1)
    else $error("half step forward wrong");
  a_full_fwd: assert property (step_evt && !exc_s && !dir_s && !pos[0] && !int_rst
      |=> pos == $past(pos) + 3'h2)
    else $error("full step forward wrong");
  a_half_rev: assert property (step_evt && exc_s && dir_s && !int_rst
      |=> pos == $past(pos) - 3'h1)
    else $error("half step reverse wrong");
  a_full_rev: assert property (step_evt && !exc_s && dir_s && !pos[0] && !int_rst
      |=> pos == $past(pos) - 3'h2)
    else $error("full step reverse wrong");
  a_mode_switch: assert property (step_evt && !exc_s && pos[0] && !int_rst
      |=> !pos[0])
    else $error("full mode left on half state");

  // Reset, enable and fault
  a_reset_home: assert property (!rstn_s
      |=> pos == 3'h0 && !FIRST_WINDING_FWD && !SECOND_WINDING_REV)
    else $error("reset pin did not hold home");
  a_start_state: assert property ($rose(rstn_s) && en_s && run && !fault && !step_evt
      ##1 !step_evt && en_s && run && !fault |=> FIRST_WINDING_FWD && SECOND_WINDING_REV)
    else $error("wrong state after reset release");
  a_enable_off: assert property (!en_s |=> !FIRST_WINDING_FWD && !FIRST_WINDING_REV
      && !SECOND_WINDING_FWD && !SECOND_WINDING_REV)
    else $error("windings driven while disabled");
  a_enable_hold: assert property (!en_s && !int_rst |=> pos == $past(pos))
    else $error("position changed while disabled");
  a_fault_latch: assert property ((oc_s || oh_s) && !int_rst
      |=> fault ##1 !ALARM_OE_N && !FIRST_WINDING_FWD)
    else $error("fault not latched onto alarm");
  a_fault_sticky: assert property (fault && !int_rst |=> fault)
    else $error("fault latch cleared without reset");
  a_alarm_idle: assert property (!fault |=> ALARM_OE_N && !ALARM_O)
    else $error("alarm driven without fault");

  // Winding patterns: even states drive one of each pair, odd states one winding
  a_wind_two: assert property (run && en_s && !fault && !int_rst && !pos[0]
      |=> (FIRST_WINDING_FWD != FIRST_WINDING_REV)
      && (SECOND_WINDING_FWD != SECOND_WINDING_REV))
    else $error("two-phase state not on two windings");
  a_wind_one: assert property (run && en_s && !fault && !int_rst && pos[0]
      |=> $countones({FIRST_WINDING_FWD, FIRST_WINDING_REV,
      SECOND_WINDING_FWD, SECOND_WINDING_REV}) == 1)
    else $error("half state not on one winding");

  // Interrupts
  a_irq_step: assert property (step_evt && !int_rst |=> irq_status[`SSQ_IRQ_STEP_BIT])
    else $error("step event not recorded");
  a_irq_out: assert property (|(irq_status & irq_mask) |=> IRQ)
    else $error("unmasked status did not raise interrupt");

endmodule : ssq_sequencer

//--- verilog/ssq_defs.svh
// Constants of the stepper phase sequencer: register map, fields, resets.
// Assumes inclusion by bare name from the sequencer design files.
// How it works
// - Each active step-clock edge advances the winding pattern exactly one step.
// - Edge select high steps on rising edges only; low steps on both edges.
// - Excitation select low gives 2-phase stepping; high gives 1-2 half stepping.
// - Direction select low steps forward; high steps in reverse order.
// - A low level on the reset pin holds the sequencer in reset.
// - Leaving reset starts at first-forward plus second-reverse winding state.
// - Enable low forces all four winding outputs off.
// - Enable high again resumes from the held position, nothing reset or skipped.
// - Overcurrent or overheat latches, kills outputs, pulls alarm low until reset.
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH

// ==========================================================
// Register byte offsets
`define SSQ_CTRL_OFS 8'h00
`define SSQ_STATE_OFS 8'h04
`define SSQ_IRQ_STATUS_OFS 8'h08
`define SSQ_IRQ_MASK_OFS 8'h0c
`define SSQ_ADDR_MSB 7

// ==========================================================
// Fields
`define SSQ_CTRL_RUN_BIT 0
`define SSQ_CTRL_RESET 32'h0000_0001
// Synchroniser reset: reset pin reads released, all other pins low
`define SSQ_SYNC_RESET 8'h40
`define SSQ_IRQ_STEP_BIT 0
`define SSQ_IRQ_FAULT_BIT 1
`define SSQ_IRQ_W 2

// ==========================================================
// Sequence constants
`define SSQ_POS_HOME 3'h0
`define SSQ_POS_ONE 3'h1
`define SSQ_POS_TWO 3'h2
`define SSQ_WIND_OFF 4'h0

`endif

//--- verilog/ssq_pkg.sv
// Types shared by the stepper phase sequencer.
// Assumes no other package.
package ssq_pkg;
  // Half-step position, 0 is the reset state
  typedef logic [2:0] ssq_pos_t;
  // Winding drive order: {second_rev, second_fwd, first_rev, first_fwd}
  typedef logic [3:0] ssq_wind_t;
  typedef logic [31:0] ssq_word_t;
endpackage : ssq_pkg

//--- verif/ssq_ctrl_model.sv
// Step and direction controller model driving the sequencer pins.
// Assumes go pulses only while busy is low; edges is even.
`timescale 1ns/1ps
module ssq_ctrl_model (
  input wire logic go,
  input wire logic [2:0] mode,
  input wire logic [3:0] edges,
  output logic step_clk,
  output logic exc,
  output logic edg,
  output logic dir,
  output logic busy
);
  // ====
  // Frame: selects settle, step clock toggles every 160 ns, selects held
  initial begin
    {step_clk, exc, edg, dir, busy} = 5'h00;
    forever begin
      @(posedge go);
      busy = 1'h1;
      {exc, edg, dir} = mode;
      #7000;
      repeat (edges) #160 step_clk = ~step_clk;
      #7000;
      busy = 1'h0;
    end
  end
endmodule : ssq_ctrl_model

//--- verif/ssq_sequencer_test.sv
// Self-checking bench of the stepper phase sequencer.
// Assumes the controller model owns the step and select pins.
`timescale 1ns/1ps
module ssq_sequencer_test;
  logic clk, srst, rst_n, en, oc, oh, hsel, hwrite, go, f1, r1, f2, r2;
  logic stp, exc, edg, dir, busy, al_o, al_oe_n, irq, hrdy, hresp;
  logic [1:0] htrans;
  logic [2:0] mode, pos;
  logic [3:0] edges;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] wtab [8] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'ha, 4'h8};
  int failures = 0;
  int cmp_count = 0;
  ssq_ctrl_model i_ctrl (.go(go), .mode(mode), .edges(edges), .step_clk(stp),
    .exc(exc), .edg(edg), .dir(dir), .busy(busy));
  ssq_sequencer i_dut (.CORE_CLK(clk), .SRST(srst), .STEP_CLK(stp),
    .EXCITATION_SELECT(exc), .EDGE_SELECT(edg), .DIRECTION_SELECT(dir),
    .RESET_N_IN(rst_n), .ENABLE(en), .OVERCURRENT(oc), .OVERHEAT(oh),
    .FIRST_WINDING_FWD(f1), .FIRST_WINDING_REV(r1), .SECOND_WINDING_FWD(f2),
    .SECOND_WINDING_REV(r2), .ALARM_O(al_o), .ALARM_OE_N(al_oe_n), .IRQ(irq),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp));
  // ====
  // Helpers
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] wind();
    return {28'h0, r2, f2, r1, f1};
  endfunction : wind
  function automatic logic [31:0] ew();
    return {28'h0, wtab[pos]};
  endfunction : ew
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Zero wait is not assumed; the bound only catches a hang
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'h1 && n < 20);
    if (n >= 20) begin
      failures++;
      close_out();
    end
  endtask : rdy
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr
  task rchk(input logic [31:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rchk
  // Mode is {exc, edge, dir}; act says whether the edges should count
  task frame(input logic [2:0] m, input logic [3:0] t, input logic act);
    int n;
    mode <= m;
    edges <= t;
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'h0 && n < 2000);
    if (n >= 2000) begin
      failures++;
      close_out();
    end
    for (int i = 0; i < (m[1] ? t / 2 : t); i++) begin
      if (act) pos = m[0] ? pos - ((m[2] | pos[0]) ? 3'h1 : 3'h2)
                          : pos + ((m[2] | pos[0]) ? 3'h1 : 3'h2);
    end
  endtask : frame
  // ====
  // Scenarios
  task t_reset;
    chk("wind", wind(), 32'h9);
    rchk(32'h0, 32'h1, "ctrl");
    rchk(32'h4, 32'h600, "state");
    rchk(32'hc, 32'h0, "mask");
    wr(32'h10, 32'hffff_ffff);
    rchk(32'h10, 32'h0, "unmapped");
  endtask : t_reset
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      frame(3'(i), 4'h4, 1'h1);
      chk("wind", wind(), ew());
      rchk(32'h4, {20'h0, 3'h3, i[0], i[1], i[2], 3'h0, pos}, "state");
    end
    frame(3'h6, 4'h2, 1'h1);
    chk("wind", wind(), ew());
    frame(3'h1, 4'h2, 1'h1);
    chk("wind", wind(), ew());
  endtask : t_modes
  task t_enable;
    en <= 1'h0;
    cyc(5);
    chk("wind", wind(), 32'h0);
    frame(3'h4, 4'h4, 1'h0);
    en <= 1'h1;
    cyc(5);
    chk("wind", wind(), ew());
    wr(32'h0, 32'h0);
    cyc(3);
    chk("wind", wind(), 32'h0);
    wr(32'h0, 32'h1);
    cyc(3);
    chk("wind", wind(), ew());
  endtask : t_enable
  task t_irq;
    wr(32'h8, 32'h3);
    wr(32'hc, 32'h1);
    cyc(3);
    chk("irq", {31'h0, irq}, 32'h0);
    frame(3'h4, 4'h2, 1'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk(32'h8, 32'h1, "status");
    wr(32'h8, 32'h1);
    cyc(3);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(32'hc, 32'h0);
  endtask : t_irq
  task t_fault;
    wr(32'hc, 32'h2);
    oh <= 1'h1;
    cyc(4);
    oh <= 1'h0;
    cyc(4);
    chk("alarm", {31'h0, al_oe_n}, 32'h0);
    chk("alarm_o", {31'h0, al_o}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    frame(3'h4, 4'h2, 1'h0);
    chk("wind", wind(), 32'h0);
    rchk(32'h8, 32'h2, "status");
    rst_n <= 1'h0;
    cyc(6);
    chk("wind", wind(), 32'h0);
    frame(3'h4, 4'h2, 1'h0);
    rst_n <= 1'h1;
    pos = 3'h0;
    cyc(250);
    chk("wind", wind(), 32'h9);
    chk("alarm", {31'h0, al_oe_n}, 32'h1);
    oc <= 1'h1;
    cyc(4);
    oc <= 1'h0;
    cyc(4);
    chk("alarm", {31'h0, al_oe_n}, 32'h0);
  endtask : t_fault
  initial begin
    {srst, rst_n, en, oc, oh, hsel, hwrite, go} = 8'he0;
    {htrans, mode, edges, haddr, hwdata, pos} = 76'h0;
    srst = 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    cyc(4);
    t_reset();
    t_modes();
    t_enable();
    t_irq();
    t_fault();
    close_out();
  end
endmodule : ssq_sequencer_test
